// ### sat_dev.sv
// Converter end: select filter, serial address and result shifting, conversion sequencing
// Contract
// - test addresses give codes 512, 0, 1023
// - acquisition spans six serial clock periods
// - conversion ends within 21 us
// - select low after tenth edge aborts
// - flag falls soon after tenth falling edge
// - MSB presented when flag rises
// - output driven fast, released within 150 ns
// - select level accepted after 1.425 us
// - host waits select setup before clocking
// - deselect stops address and clock response
// - no-select short mode waits for flag
// - eleventh rising edge precedes conversion end
// - no-select long mode uses sixteen clocks
// - out-of-range inputs saturate to ends
// - address and codes are positive logic
// - ten, eleven-to-sixteen and sixteen clock modes
// - valid select fall restarts, keeps result
// - host rises clock within 9.5 us
`timescale 1ns/1ns
module sat_dev #(
	parameter int FILT_CYC = sat_pkg::CS_FILT_CYC,
	parameter int STEP_CYC = sat_pkg::SAR_STEP_CYC
) (
	input  wire logic                 ref_clk,
	input  wire logic                 sys_rst,
	sat_link_if.dev                   link,
	input  wire sat_pkg::sat_level_t  ain [sat_pkg::NUM_CH],
	output logic [sat_pkg::RES_W-1:0] result,
	output logic                      result_strobe,
	output logic                      busy
);
	import sat_pkg::*;

	if (FILT_CYC < 1 || FILT_CYC > 255 || STEP_CYC < 1 || STEP_CYC > 255) begin : g_chk
		$error("sat_dev: filter or step count out of range");
	end

	sat_dev_state_t    state;
	logic [1:0]        cs_s;
	logic [2:0]        clk_s;
	logic [1:0]        addr_s;
	logic              cs_f;
	logic [7:0]        filt_cnt;
	logic              cs_fall;
	logic              cs_rise;
	logic [2:0]        rise_cnt;
	logic [4:0]        fall_cnt;
	logic [ADDR_W-1:0] addr_sh;
	logic [RES_W-1:0]  sample;
	logic [RES_W-1:0]  out_sh;
	logic [RES_W-1:0]  sar;
	logic [RES_W-1:0]  trial;
	logic [RES_W-1:0]  next_sar;
	logic [RES_W-1:0]  pick_level;
	logic [3:0]        sar_idx;
	logic [7:0]        step_cnt;
	logic              long_xfer;
	logic              io_rise;
	logic              io_fall;

	function automatic logic [RES_W-1:0] clamp_level(input sat_level_t v);
		if (v < 0)
			return CODE_ZERO;
		else if (v > LEVEL_FULL)
			return CODE_FULL;
		else
			return v[RES_W-1:0];
	endfunction

	// Pins come from the host's domain
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cs_s   <= 2'h3;
			clk_s  <= 3'h0;
			addr_s <= 2'h0;
		end else begin
			cs_s   <= {cs_s[0], link.cs_n};
			clk_s  <= {clk_s[1:0], link.io_clk};
			addr_s <= {addr_s[0], link.addr};
		end
	end

	// Clock edges count only while select is accepted low
	assign io_rise = clk_s[1] & ~clk_s[2] & ~cs_f;
	assign io_fall = ~clk_s[1] & clk_s[2] & ~cs_f;

	// Glitch filter: a new select level must persist before it counts
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cs_f     <= 1'b1;
			filt_cnt <= 8'h00;
			cs_fall  <= 1'b0;
			cs_rise  <= 1'b0;
		end else begin
			cs_fall <= 1'b0;
			cs_rise <= 1'b0;
			if (cs_s[1] == cs_f) begin
				filt_cnt <= 8'h00;
			end else if (filt_cnt == 8'(FILT_CYC - 1)) begin
				cs_f     <= cs_s[1];
				filt_cnt <= 8'h00;
				cs_fall  <= ~cs_s[1];
				cs_rise  <= cs_s[1];
			end else begin
				filt_cnt <= filt_cnt + 8'h01;
			end
		end
	end

	// Enable follows the raw select so the MSB appears before the filter settles
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			link.dout_oe <= 1'b0;
		else
			link.dout_oe <= ~cs_s[1];
	end

	// Channel mux with self-test levels; addresses 14 and 15 read as zero
	always_comb begin
		pick_level = CODE_ZERO;
		if (addr_sh == ADDR_TEST_MID)
			pick_level = CODE_MID;
		else if (addr_sh == ADDR_TEST_ZERO)
			pick_level = CODE_ZERO;
		else if (addr_sh == ADDR_TEST_FULL)
			pick_level = CODE_FULL;
		else if (addr_sh < 4'(NUM_CH))
			pick_level = clamp_level(ain[addr_sh]);
	end

	// One trial bit per step, MSB first
	assign trial    = sar | (CODE_MID >> sar_idx);
	assign next_sar = (sample >= trial) ? trial : sar;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state         <= ST_OFF;
			rise_cnt      <= 3'h0;
			fall_cnt      <= 5'h00;
			addr_sh       <= 4'h0;
			sample        <= 10'h000;
			out_sh        <= 10'h000;
			sar           <= 10'h000;
			sar_idx       <= 4'h0;
			step_cnt      <= 8'h00;
			long_xfer     <= 1'b0;
			result        <= 10'h000;
			result_strobe <= 1'b0;
			busy          <= 1'b0;
			link.dout     <= 1'b0;
			link.eoc      <= 1'b1;
		end else begin
			result_strobe <= 1'b0;
			if (cs_fall) begin
				// Abort keeps the old result; the flag returns high
				state     <= ST_XFER;
				busy      <= 1'b0;
				rise_cnt  <= 3'h0;
				fall_cnt  <= 5'h00;
				out_sh    <= result;
				link.dout <= result[RES_W-1];
				link.eoc  <= 1'b1;
			end else if (cs_rise && state != ST_CONV) begin
				state     <= ST_OFF;
				out_sh    <= result;
				link.dout <= result[RES_W-1];
			end else begin
				case (state)
					ST_XFER: begin
						if (io_rise && rise_cnt < 3'(ADDR_CLKS)) begin
							addr_sh  <= {addr_sh[ADDR_W-2:0], addr_s[1]};
							rise_cnt <= rise_cnt + 3'h1;
						end
						if (io_fall) begin
							fall_cnt  <= fall_cnt + 5'h01;
							out_sh    <= {out_sh[RES_W-2:0], 1'b0};
							link.dout <= out_sh[RES_W-2];
							if (fall_cnt == 5'(XFER_CLKS - 1)) begin
								// Hold the input sampled since the fourth falling edge
								sample    <= pick_level;
								link.eoc  <= 1'b0;
								state     <= ST_CONV;
								busy      <= 1'b1;
								sar       <= 10'h000;
								sar_idx   <= 4'h0;
								step_cnt  <= 8'h00;
								long_xfer <= 1'b0;
							end
						end
					end
					ST_CONV: begin
						// Output is off now; park the old MSB so an abort shows it at once
						if (cs_rise)
							link.dout <= result[RES_W-1];
						if (io_rise)
							long_xfer <= 1'b1;
						if (io_fall && fall_cnt != 5'(LONG_CLKS))
							fall_cnt <= fall_cnt + 5'h01;
						if (step_cnt == 8'(STEP_CYC - 1)) begin
							step_cnt <= 8'h00;
							sar      <= next_sar;
							sar_idx  <= sar_idx + 4'h1;
							if (sar_idx == 4'(RES_W - 1)) begin
								result        <= next_sar;
								result_strobe <= 1'b1;
								busy          <= 1'b0;
								link.eoc      <= 1'b1;
								out_sh        <= next_sar;
								link.dout     <= next_sar[RES_W-1];
								rise_cnt      <= 3'h0;
								if (cs_f) begin
									state <= ST_OFF;
								end else if (long_xfer || io_rise) begin
									state <= ST_TAIL;
								end else begin
									state    <= ST_XFER;
									fall_cnt <= 5'h00;
								end
							end
						end else begin
							step_cnt <= step_cnt + 8'h01;
						end
					end
					ST_TAIL: begin
						// Late clocks of a long transfer; a 16th fall starts the next cycle
						if (fall_cnt == 5'(LONG_CLKS)) begin
							// All sixteen came during conversion, so nothing is left to wait for
							state    <= ST_XFER;
							fall_cnt <= 5'h00;
							rise_cnt <= 3'h0;
						end else if (io_fall) begin
							if (fall_cnt >= 5'(LONG_CLKS - 1)) begin
								state    <= ST_XFER;
								fall_cnt <= 5'h00;
								rise_cnt <= 3'h0;
							end else begin
								fall_cnt <= fall_cnt + 5'h01;
							end
						end
					end
					default: begin
						state <= ST_OFF;
					end
				endcase
			end
		end
	end
endmodule

// ### sat_host.sv
// Host end: drives select, serial clock and address, gathers the returned result
`timescale 1ns/1ns
module sat_host #(
	parameter int HALF_CYC  = sat_pkg::IOCLK_HALF_CYC,
	parameter int SETUP_CYC = sat_pkg::CS_SETUP_CYC,
	parameter int WAIT_CYC  = sat_pkg::EOC_WAIT_CYC
) (
	input  wire logic                  ref_clk,
	input  wire logic                  sys_rst,
	sat_link_if.host                   link,
	input  wire logic                  start,
	input  wire logic                  use_cs,
	input  wire logic [4:0]            clk_count,
	input  wire logic [sat_pkg::ADDR_W-1:0] chan,
	output logic [sat_pkg::RES_W-1:0]  prev_result,
	output logic                       result_valid,
	output logic                       busy,
	output logic                       timeout
);
	import sat_pkg::*;

	// Slower clock leaves the data line time to pass the sync stages
	if (HALF_CYC < 8 || HALF_CYC > 15 || SETUP_CYC < CS_FILT_CYC + 4 || SETUP_CYC > 1023 ||
		WAIT_CYC < 2 || WAIT_CYC > 1023) begin : g_chk
		$error("sat_host: timing parameter out of range");
	end

	sat_host_state_t   state;
	logic [1:0]        eoc_s;
	logic [1:0]        dout_s;
	logic [9:0]        cnt;
	logic [3:0]        half_cnt;
	logic [4:0]        falls;
	logic [4:0]        rises;
	logic [4:0]        ncl;
	logic              cs_mode;
	logic              eoc_low_seen;
	logic [ADDR_W-1:0] addr_sh;
	logic [RES_W-1:0]  rx_sh;

	// Without select only 10 or 16 clocks are allowed; with it 10 to 16
	function automatic logic [4:0] clocks_for(input logic cs, input logic [4:0] n);
		if (!cs)
			return (n == 5'(XFER_CLKS)) ? 5'(XFER_CLKS) : 5'(LONG_CLKS);
		else if (n < 5'(XFER_CLKS))
			return 5'(XFER_CLKS);
		else if (n > 5'(LONG_CLKS))
			return 5'(LONG_CLKS);
		else
			return n;
	endfunction

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			eoc_s  <= 2'h3;
			dout_s <= 2'h0;
		end else begin
			eoc_s  <= {eoc_s[0], link.eoc};
			dout_s <= {dout_s[0], link.dout_line};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state        <= H_IDLE;
			cnt          <= 10'h000;
			half_cnt     <= 4'h0;
			falls        <= 5'h00;
			rises        <= 5'h00;
			ncl          <= 5'h00;
			cs_mode      <= 1'b0;
			eoc_low_seen <= 1'b0;
			addr_sh      <= 4'h0;
			rx_sh        <= 10'h000;
			prev_result  <= 10'h000;
			result_valid <= 1'b0;
			busy         <= 1'b0;
			timeout      <= 1'b0;
			link.cs_n    <= 1'b1;
			link.io_clk  <= 1'b0;
			link.addr    <= 1'b0;
		end else begin
			result_valid <= 1'b0;
			if (!eoc_s[1])
				eoc_low_seen <= 1'b1;
			if (cnt != 10'h3ff)
				cnt <= cnt + 10'h001;
			case (state)
				H_IDLE: begin
					if (start) begin
						cs_mode      <= use_cs;
						ncl          <= clocks_for(use_cs, clk_count);
						addr_sh      <= chan;
						link.addr    <= chan[ADDR_W-1];
						falls        <= 5'h00;
						rises        <= 5'h00;
						half_cnt     <= 4'h0;
						cnt          <= 10'h000;
						busy         <= 1'b1;
						timeout      <= 1'b0;
						eoc_low_seen <= 1'b0;
						if (use_cs && !link.cs_n) begin
							link.cs_n <= 1'b1;
							state     <= H_GAP;
						end else if (link.cs_n) begin
							link.cs_n <= 1'b0;
							state     <= H_SETUP;
						end else begin
							state <= H_CLK;
						end
					end
				end
				H_GAP: begin
					if (cnt >= 10'(SETUP_CYC - 1)) begin
						link.cs_n <= 1'b0;
						cnt       <= 10'h000;
						state     <= H_SETUP;
					end
				end
				H_SETUP: begin
					if (cnt >= 10'(SETUP_CYC - 1))
						state <= H_CLK;
				end
				H_CLK: begin
					if (half_cnt == 4'(HALF_CYC - 1)) begin
						half_cnt    <= 4'h0;
						link.io_clk <= ~link.io_clk;
						if (!link.io_clk) begin
							if (rises < 5'(RES_W))
								rx_sh <= {rx_sh[RES_W-2:0], dout_s[1]};
							rises <= rises + 5'h01;
						end else begin
							falls     <= falls + 5'h01;
							addr_sh   <= {addr_sh[ADDR_W-2:0], 1'b0};
							link.addr <= addr_sh[ADDR_W-2];
							if (falls == 5'(XFER_CLKS - 1))
								cnt <= 10'h000;
							if (falls == ncl - 5'h01) begin
								prev_result  <= rx_sh;
								result_valid <= 1'b1;
								state        <= H_WAIT;
								if (cs_mode)
									link.cs_n <= 1'b1;
							end
						end
					end else begin
						half_cnt <= half_cnt + 4'h1;
					end
				end
				H_WAIT: begin
					if (start && cs_mode && use_cs && cnt >= 10'(SETUP_CYC) && cnt < 10'(ABORT_CYC)) begin
						// Early select fall cuts the running conversion short
						ncl          <= clocks_for(1'b1, clk_count);
						addr_sh      <= chan;
						link.addr    <= chan[ADDR_W-1];
						falls        <= 5'h00;
						rises        <= 5'h00;
						half_cnt     <= 4'h0;
						cnt          <= 10'h000;
						eoc_low_seen <= 1'b0;
						link.cs_n    <= 1'b0;
						state        <= H_SETUP;
					end else if (eoc_low_seen && eoc_s[1] && (!cs_mode || cnt >= 10'(SETUP_CYC))) begin
						busy  <= 1'b0;
						state <= H_IDLE;
					end else if (cnt >= 10'(WAIT_CYC - 1)) begin
						busy    <= 1'b0;
						timeout <= 1'b1;
						state   <= H_IDLE;
					end
				end
				default: begin
					state <= H_IDLE;
				end
			endcase
		end
	end
endmodule

// ### sat_link_if.sv
// Four-wire link plus end-of-conversion flag between host and converter
`timescale 1ns/1ns
interface sat_link_if;
	logic cs_n;
	logic io_clk;
	logic addr;
	logic dout;
	logic dout_oe;
	logic eoc;
	logic dout_line;
	// Released line reads low, as with a weak pull-down
	assign dout_line = dout_oe ? dout : 1'b0;
	modport dev (
		input  cs_n,
		input  io_clk,
		input  addr,
		output dout,
		output dout_oe,
		output eoc
	);
	modport host (
		output cs_n,
		output io_clk,
		output addr,
		input  dout_line,
		input  eoc
	);
endinterface

// ### sat_link_properties.sv
// Timing checks on the link between host and converter ends
`timescale 1ns/1ns
module sat_link_properties (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic cs_n,
	input wire logic io_clk,
	input wire logic addr,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic eoc,
	input wire logic dout_line
);
	// 21 us at 50 ns plus the few cycles between clock pin and conversion start
	localparam int CONV_LIM = 425;
	logic [7:0] io_q;
	logic [5:0] hi_cnt;
	logic [5:0] lo_cnt;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	// Short history of the serial clock pin
	always_ff @(posedge ref_clk) begin
		io_q <= {io_q[6:0], io_clk};
	end

	// Cycles select has stood high, saturating
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !cs_n) begin
			hi_cnt <= 6'h00;
		end else if (hi_cnt != 6'h3f) begin
			hi_cnt <= hi_cnt + 6'h01;
		end
	end

	// Cycles select has stood low, saturating
	always_ff @(posedge ref_clk) begin
		if (sys_rst || cs_n) begin
			lo_cnt <= 6'h00;
		end else if (lo_cnt != 6'h3f) begin
			lo_cnt <= lo_cnt + 6'h01;
		end
	end

	chk_clk_after_setup: assert property ($rose(io_clk) |-> lo_cnt >= 6'(sat_pkg::CS_FILT_CYC))
		else $error("clock rose before select setup elapsed");
	chk_oe_on_select: assert property ($fell(cs_n) |-> ##3 dout_oe)
		else $error("data output not driven after select fell");
	chk_oe_off_deselect: assert property ($rose(cs_n) |-> ##3 !dout_oe)
		else $error("data output not released after select rose");
	chk_eoc_fall_cause: assert property ($fell(eoc) |-> !io_q[2] && io_q[7:2] != 6'h00)
		else $error("end flag fell without a recent clock fall");
	chk_conv_time_bound: assert property ($fell(eoc) |-> ##[1:CONV_LIM] eoc)
		else $error("conversion ran too long");
	chk_select_setup_wait: assert property ($fell(cs_n) |-> (!io_clk)[*8])
		else $error("clock started inside select setup");
	chk_deselect_stops: assert property ($fell(eoc) |-> hi_cnt < 6'd40)
		else $error("conversion started long after deselect");
	chk_addr_hold_rise: assert property ($rose(io_clk) |-> $stable(addr) && addr == $past(addr, 2))
		else $error("address moved around clock rise");
	chk_clk_high_width: assert property ($rose(io_clk) |-> io_clk[*4])
		else $error("serial clock high phase too short");
endmodule

// ### sat_pkg.sv
// Shared constants and types of the serial converter link
package sat_pkg;
	localparam int CLK_NS         = 50;
	localparam int CS_FILT_NS     = 1425;
	localparam int CS_FILT_CYC    = (CS_FILT_NS + CLK_NS - 1) / CLK_NS;
	localparam int CONV_NS        = 21000;
	localparam int CONV_CYC       = CONV_NS / CLK_NS;
	localparam int ABORT_NS       = 9000;
	localparam int ABORT_CYC      = ABORT_NS / CLK_NS;
	localparam int RES_W          = 10;
	localparam int ADDR_W         = 4;
	localparam int NUM_CH         = 11;
	localparam int ADDR_CLKS      = 4;
	localparam int ACQ_CLKS       = 6;
	localparam int XFER_CLKS      = ADDR_CLKS + ACQ_CLKS;
	localparam int LONG_CLKS      = 16;
	localparam int SAR_STEP_CYC   = CONV_CYC / RES_W;
	localparam int CS_SETUP_CYC   = CS_FILT_CYC + 11;
	localparam int IOCLK_HALF_CYC = 8;
	localparam int EOC_WAIT_CYC   = CONV_CYC + 100;
	localparam logic [ADDR_W-1:0] ADDR_TEST_MID  = 4'hb;
	localparam logic [ADDR_W-1:0] ADDR_TEST_ZERO = 4'hc;
	localparam logic [ADDR_W-1:0] ADDR_TEST_FULL = 4'hd;
	localparam logic [RES_W-1:0]  CODE_MID       = 10'h200;
	localparam logic [RES_W-1:0]  CODE_ZERO      = 10'h000;
	localparam logic [RES_W-1:0]  CODE_FULL      = 10'h3ff;
	typedef logic signed [11:0] sat_level_t;
	localparam sat_level_t LEVEL_FULL = 12'sh3ff;
	typedef enum logic [3:0] {
		ST_OFF  = 4'h1,
		ST_XFER = 4'h2,
		ST_CONV = 4'h4,
		ST_TAIL = 4'h8
	} sat_dev_state_t;
	typedef enum logic [4:0] {
		H_IDLE  = 5'h01,
		H_GAP   = 5'h02,
		H_SETUP = 5'h04,
		H_CLK   = 5'h08,
		H_WAIT  = 5'h10
	} sat_host_state_t;
endpackage

// ### serial_adc_transfer_control_tb.sv
// Self-checking bench: host end and converter end joined over the link
`timescale 1ns/1ns
module serial_adc_transfer_control_tb;
	import sat_pkg::*;
	logic                 ref_clk;
	logic                 sys_rst;
	logic                 start;
	logic                 use_cs;
	logic [4:0]           clk_count;
	logic [ADDR_W-1:0]    chan;
	logic [RES_W-1:0]     prev_result;
	logic                 result_valid;
	logic                 host_busy;
	logic                 timeout;
	sat_level_t           ain [NUM_CH];
	logic [RES_W-1:0]     result;
	logic                 result_strobe;
	logic                 dev_busy;
	logic [RES_W-1:0]     exp_last;
	int                   num_errors;
	int                   n_checks;
	int                   n_strobe;
	int                   n_valid;
	logic                 start_f;
	logic [RES_W-1:0]     prev_result_f;
	logic                 busy_f;
	logic                 timeout_f;
	logic [RES_W-1:0]     result_f;
	logic [RES_W-1:0]     exp_fast;

	sat_link_if sat_link_if_inst ();
	sat_link_if sat_link_if_fast ();

	sat_host sat_host_inst (
		.ref_clk      (ref_clk),
		.sys_rst      (sys_rst),
		.link         (sat_link_if_inst.host),
		.start        (start),
		.use_cs       (use_cs),
		.clk_count    (clk_count),
		.chan         (chan),
		.prev_result  (prev_result),
		.result_valid (result_valid),
		.busy         (host_busy),
		.timeout      (timeout)
	);

	sat_dev sat_dev_inst (
		.ref_clk       (ref_clk),
		.sys_rst       (sys_rst),
		.link          (sat_link_if_inst.dev),
		.ain           (ain),
		.result        (result),
		.result_strobe (result_strobe),
		.busy          (dev_busy)
	);

	// Second pair with a short conversion, so sixteen clocks outlast it
	sat_host sat_host_fast_inst (
		.ref_clk      (ref_clk),
		.sys_rst      (sys_rst),
		.link         (sat_link_if_fast.host),
		.start        (start_f),
		.use_cs       (use_cs),
		.clk_count    (clk_count),
		.chan         (chan),
		.prev_result  (prev_result_f),
		.result_valid (),
		.busy         (busy_f),
		.timeout      (timeout_f)
	);

	sat_dev #(
		.STEP_CYC (2)
	) sat_dev_fast_inst (
		.ref_clk       (ref_clk),
		.sys_rst       (sys_rst),
		.link          (sat_link_if_fast.dev),
		.ain           (ain),
		.result        (result_f),
		.result_strobe (),
		.busy          ()
	);

	sat_link_properties sat_link_properties_inst (
		.ref_clk   (ref_clk),
		.sys_rst   (sys_rst),
		.cs_n      (sat_link_if_inst.cs_n),
		.io_clk    (sat_link_if_inst.io_clk),
		.addr      (sat_link_if_inst.addr),
		.dout      (sat_link_if_inst.dout),
		.dout_oe   (sat_link_if_inst.dout_oe),
		.eoc       (sat_link_if_inst.eoc),
		.dout_line (sat_link_if_inst.dout_line)
	);

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		if (result_strobe === 1'b1) begin
			n_strobe++;
		end
		if (result_valid === 1'b1) begin
			n_valid++;
		end
	end

	task automatic check(input string what, input logic [RES_W-1:0] seen, input logic [RES_W-1:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Codes worked out from levels; ends saturate, test inputs fixed
	function automatic logic [RES_W-1:0] code_of(input logic [ADDR_W-1:0] ch);
		if (ch == 4'hb) return 10'h200;
		if (ch == 4'hc) return 10'h000;
		if (ch == 4'hd) return 10'h3ff;
		if (ch >= 4'hb) return 10'h000;
		if (ain[ch] < 0) return 10'h000;
		if (ain[ch] > 12'sh3ff) return 10'h3ff;
		return ain[ch][RES_W-1:0];
	endfunction

	task automatic pulse_start(input logic cs, input logic [4:0] n, input logic [ADDR_W-1:0] ch);
		@(posedge ref_clk);
		#5;
		use_cs    = cs;
		clk_count = n;
		chan      = ch;
		start     = 1'b1;
		@(posedge ref_clk);
		#5;
		start = 1'b0;
	endtask

	// Bounded wait, since a lost handshake must not hang the run
	task automatic wait_idle;
		for (int i = 0; i < 3000; i++) begin
			@(posedge ref_clk);
			#5;
			if (host_busy === 1'b0) begin
				break;
			end
		end
		check("host busy", {9'h000, host_busy}, 10'h000);
		check("host timeout", {9'h000, timeout}, 10'h000);
		check("device busy", {9'h000, dev_busy}, 10'h000);
	endtask

	// One whole transfer: old code returned, new code converted
	task automatic run_xfer(input logic cs, input logic [4:0] n, input logic [ADDR_W-1:0] ch);
		int v0;
		v0 = n_valid;
		pulse_start(cs, n, ch);
		wait_idle();
		check("valid pulses", 10'(n_valid - v0), 10'h001);
		check("returned code", prev_result, exp_last);
		exp_last = code_of(ch);
		check("converted code", result, exp_last);
	endtask

	// Select pulled low mid-conversion: old result kept, one strobe only
	task automatic run_abort(input logic [ADDR_W-1:0] ch_a, input logic [ADDR_W-1:0] ch_b);
		int s0;
		s0 = n_strobe;
		pulse_start(1'b1, 5'd10, ch_a);
		for (int i = 0; i < 1500; i++) begin
			@(posedge ref_clk);
			#5;
			if (sat_link_if_inst.eoc === 1'b0) begin
				break;
			end
		end
		repeat (60) @(posedge ref_clk);
		check("kept result", result, exp_last);
		pulse_start(1'b1, 5'd10, ch_b);
		wait_idle();
		check("returned after abort", prev_result, exp_last);
		exp_last = code_of(ch_b);
		check("code after abort", result, exp_last);
		check("strobe count", 10'(n_strobe - s0), 10'h001);
	endtask

	// Sixteen clocks on the fast pair: device idles after conversion until the last fall
	task automatic run_long(input logic cs, input logic [ADDR_W-1:0] ch);
		@(posedge ref_clk);
		#5;
		use_cs    = cs;
		clk_count = 5'd16;
		chan      = ch;
		start_f   = 1'b1;
		@(posedge ref_clk);
		#5;
		start_f = 1'b0;
		for (int i = 0; i < 3000 && busy_f !== 1'b0; i++) begin
			@(posedge ref_clk);
			#5;
		end
		check("long busy", {9'h000, busy_f}, 10'h000);
		check("long timeout", {9'h000, timeout_f}, 10'h000);
		check("long returned", prev_result_f, exp_fast);
		exp_fast = code_of(ch);
		check("long converted", result_f, exp_fast);
	endtask

	initial begin
		repeat (60000) @(posedge ref_clk);
		num_errors++;
		give_verdict();
	end

	initial begin
		sys_rst    = 1'b1;
		start      = 1'b0;
		use_cs     = 1'b1;
		clk_count  = 5'd10;
		chan       = 4'h0;
		num_errors = 0;
		n_checks   = 0;
		n_strobe   = 0;
		n_valid    = 0;
		start_f    = 1'b0;
		exp_last   = 10'h000;
		exp_fast   = 10'h000;
		for (int i = 0; i < NUM_CH; i++) begin
			ain[i] = sat_level_t'(i * 90 + 7);
		end
		ain[3] = -12'sh005;
		ain[5] = 12'sh5dc;
		ain[6] = 12'sh3ff;
		repeat (4) @(posedge ref_clk);
		#5;
		sys_rst = 1'b0;
		run_xfer(1'b1, 5'd10, 4'h0);
		run_xfer(1'b1, 5'd10, 4'h3);
		run_xfer(1'b1, 5'd13, 4'hb);
		run_xfer(1'b1, 5'd16, 4'h5);
		run_xfer(1'b0, 5'd10, 4'hc);
		run_xfer(1'b0, 5'd16, 4'hd);
		run_xfer(1'b0, 5'd16, 4'h6);
		run_xfer(1'b1, 5'd11, 4'he);
		run_xfer(1'b1, 5'd10, 4'ha);
		run_abort(4'h2, 4'h9);
		run_xfer(1'b1, 5'd10, 4'h1);
		run_long(1'b0, 4'h0);
		run_long(1'b0, 4'hd);
		run_long(1'b1, 4'h3);
		give_verdict();
	end
endmodule
